//--- flash_cmd_pkg.sv
// Summary of operation
// R1 - dummy select picks 8/6/8/10 fast-read dummy clocks
// R2 - host sets write latch before register write
// R3 - register write skips latch and busy bits
// R4 - hardware protect refuses every register write
// R5 - host frames register write opcode then data
// R6 - register write needs exactly 8 or 16 bits
// R7 - write cycle starts when chip select rises
// R8 - busy during cycle; end clears busy, latch
// R9 - software protect: latch settable, bits writable
// R10 - lock with pin low rejects register write
// R11 - lock and pin low enter hardware protect
// R12 - pin high again leaves hardware protect
// R13 - four-wire mode or quad bit disable protect
// R14 - protected region blocks program and erase
// R15 - host holds protect pin high during write
// R16 - enter-wide sets bit 5, 32-bit addressing
// R17 - exit-wide or reset leaves wide addressing
// R18 - table, signature, maker reads keep 3 bytes
// R19 - mode switch frame is opcode only
// R20 - exit-wide clears bit 5, 24-bit addressing
// R21 - address on rising, data on falling edges
// R22 - read address increments per byte, wraps
// R23 - host sends opcode, address, ends anytime
// R24 - no latch or protected target: ignore
// R25 - wide indicator zero after power-up
// R26 - opcode values are named constants
package flash_cmd_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 200;
	localparam int REG_WRITE_TIME_NS = 40000;
	localparam int REG_WRITE_CYCLES = (REG_WRITE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int ARRAY_ADDR_W = 26;
	localparam int BLOCK_ADDR_W = 16;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01; // R26
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
	localparam logic [7:0] OP_EXIT_WIDE = 8'he9;
	localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5a;
	localparam logic [7:0] OP_SIGNATURE_READ = 8'hab;
	localparam logic [7:0] OP_MAKER_PART_READ = 8'h90;

	// ----------------------------------------------------------------
	// frame bit counts
	// ----------------------------------------------------------------
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_ONE_DATA = 6'h10;
	localparam logic [5:0] BITS_TWO_DATA = 6'h18;
	localparam logic [5:0] BITS_SATURATE = 6'h3f;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic status_write_lock;
		logic quad_enable_flag;
		logic [3:0] protect_level;
		logic write_latch_flag;
		logic busy_flag;
	} status_type;

	typedef struct packed {
		logic [1:0] dummy_count_select;
		logic wide_addr_indicator;
		logic reserved;
		logic protect_origin_select;
		logic [2:0] drive_strength;
	} config_type;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h07;

	// what the link side holds after chip select rises
	typedef struct packed {
		logic fresh;
		logic [5:0] bit_cnt;
		logic [7:0] opcode;
		logic [15:0] data;
	} frame_type;

	typedef enum logic [1:0] {KIND_FAST_OUTPUT, KIND_DUAL_IO, KIND_QUAD_IO} read_kind_type;

	function automatic logic [3:0] dummy_clocks(input logic [1:0] sel, input read_kind_type kind);
		logic [3:0] n;
		n = 4'h8;
		case (kind)
			KIND_DUAL_IO:
				n = (sel == 2'h0) ? 4'h4 : (sel == 2'h1) ? 4'h6 : (sel == 2'h2) ? 4'h8 : 4'ha;
			KIND_QUAD_IO:
				n = (sel == 2'h0) ? 4'h6 : (sel == 2'h1) ? 4'h4 : (sel == 2'h2) ? 4'h8 : 4'ha;
			default:
				n = (sel == 2'h1) ? 4'h6 : (sel == 2'h3) ? 4'ha : 4'h8; // R1
		endcase
		return n;
	endfunction

	function automatic logic [2:0] addr_bytes(input logic [7:0] opcode, input logic wide);
		logic [2:0] n;
		n = wide ? 3'h4 : 3'h3; // R16
		if (opcode == OP_PARAM_TABLE_READ || opcode == OP_SIGNATURE_READ ||
			opcode == OP_MAKER_PART_READ)
			n = 3'h3; // R18
		return n;
	endfunction

endpackage

//--- bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync
(
	input wire logic i_clk, // destination clock
	input wire logic i_srst, // synchronous reset, active high
	input wire logic i_async, // level from another domain
	output logic o_sync // level after two flops
);
	logic meta;
	logic next_meta;
	logic next_sync;

	always_comb
	begin
		next_meta = i_srst ? 1'b0 : i_async;
		next_sync = i_srst ? 1'b0 : meta;
	end

	always_ff @(posedge i_clk)
	begin
		meta <= next_meta;
		o_sync <= next_sync;
	end
endmodule // bit_sync
`default_nettype wire

//--- serial_flash_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd
#(
	parameter int ADDR_W = flash_cmd_pkg::ARRAY_ADDR_W,
	parameter int REG_WRITE_CYCLES = flash_cmd_pkg::REG_WRITE_CYCLES
)
(
	input wire logic i_clk, // core clock, 200 MHz
	input wire logic i_srst, // reset or power-off, active high
	input wire logic i_sclk, // serial clock from host
	input wire logic i_cs_n, // chip select, active low
	input wire logic i_si, // serial data in
	output logic o_so, // serial data out
	output logic o_so_oe_n, // low while driving o_so
	input wire logic i_write_protect_or_io2_n, // protect pin, low protects
	input wire logic i_four_wire_cmd_mode, // four-wire command mode active
	output logic [ADDR_W-1:0] o_array_addr, // read address, sclk domain
	input wire logic [7:0] i_array_data, // array byte at o_array_addr, sclk domain
	input wire logic [ADDR_W-1:0] i_pe_addr, // program/erase target
	output logic o_pe_protected, // target lies in protected region
	output logic o_pe_allowed, // program/erase may run
	output flash_cmd_pkg::status_type o_status, // status register
	output flash_cmd_pkg::config_type o_config, // configuration register
	output logic o_hardware_protect_mode, // hardware protect active
	output logic [3:0] o_dummy_fast_output, // dummy clocks, single/dual/quad out
	output logic [3:0] o_dummy_dual_io, // dummy clocks, dual io read
	output logic [3:0] o_dummy_quad_io // dummy clocks, quad io read
);
	import flash_cmd_pkg::*;

	localparam int TIMER_W = $clog2(REG_WRITE_CYCLES + 1);

	if (ADDR_W < BLOCK_ADDR_W + 1 || ADDR_W > 32 || REG_WRITE_CYCLES < 1)
	begin : g_bad_params
		$error("serial_flash_cmd: unsupported ADDR_W or REG_WRITE_CYCLES");
	end

	// ----------------------------------------------------------------
	// link side, rising edge: shift in opcode, address, data
	// ----------------------------------------------------------------
	logic fresh;
	logic clocked;
	logic [5:0] bit_cnt;
	logic [7:0] opcode;
	logic [31:0] shreg;
	logic [ADDR_W-1:0] rd_addr;
	logic [2:0] rd_bit;
	logic rd_active;
	logic wide_link;
	logic [5:0] next_bit_cnt;
	logic [7:0] next_opcode;
	logic [31:0] next_shreg;
	logic [ADDR_W-1:0] next_rd_addr;
	logic [2:0] next_rd_bit;
	logic next_rd_active;
	logic [5:0] cnt_base;
	logic [31:0] sh_base;
	logic [5:0] addr_end;

	// wide flag settles within the eight opcode clocks
	bit_sync u_wide_sync
	(
		.i_clk(i_sclk),
		.i_srst(1'b0),
		.i_async(o_config.wide_addr_indicator),
		.o_sync(wide_link)
	);

	// chip select high marks the next edge as first of a frame
	always_ff @(posedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
			fresh <= 1'b1;
		else
			fresh <= 1'b0;
	end

	// a frame with no serial clock must not replay the previous one
	always_ff @(posedge i_cs_n)
		clocked <= ~fresh;

	always_comb
	begin
		cnt_base = fresh ? 6'h00 : bit_cnt;
		sh_base = fresh ? 32'h0000_0000 : shreg;
		next_shreg = {sh_base[30:0], i_si}; // R21
		next_bit_cnt = (cnt_base == BITS_SATURATE) ? cnt_base : cnt_base + 6'h01;
		next_opcode = (cnt_base == BITS_OPCODE - 6'h01) ? next_shreg[7:0] : opcode;
		addr_end = BITS_OPCODE + {addr_bytes(opcode, wide_link), 3'h0} - 6'h01;
		next_rd_active = fresh ? 1'b0 : rd_active;
		next_rd_addr = rd_addr;
		next_rd_bit = rd_bit;
		if (!fresh && rd_active)
		begin
			next_rd_bit = rd_bit + 3'h1;
			if (rd_bit == 3'h7)
				next_rd_addr = rd_addr + 1'b1; // R22
		end
		else if (!fresh && opcode == OP_READ && cnt_base == addr_end)
		begin
			next_rd_addr = next_shreg[ADDR_W-1:0];
			next_rd_bit = 3'h0;
			next_rd_active = 1'b1;
		end
	end

	// data registers hold through chip select high for the core to read
	always_ff @(posedge i_sclk)
	begin
		bit_cnt <= next_bit_cnt;
		opcode <= next_opcode;
		shreg <= next_shreg;
		rd_addr <= next_rd_addr;
		rd_bit <= next_rd_bit;
		rd_active <= next_rd_active;
	end

	assign o_array_addr = rd_addr;

	// ----------------------------------------------------------------
	// link side, falling edge: drive data out
	// ----------------------------------------------------------------
	logic next_so;
	logic next_so_oe_n;

	always_comb
	begin
		next_so = rd_active ? i_array_data[3'h7 - rd_bit] : 1'b0; // R21
		next_so_oe_n = ~rd_active;
	end

	// chip select high floats the output at once, with no clock
	always_ff @(negedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			o_so <= 1'b0;
			o_so_oe_n <= 1'b1;
		end
		else
		begin
			o_so <= next_so;
			o_so_oe_n <= next_so_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// crossing: frame end seen in the core clock
	// ----------------------------------------------------------------
	logic cs_sync;
	logic cs_prev;
	logic wp_sync;
	logic frame_end;
	frame_type frame;

	bit_sync u_cs_sync
	(
		.i_clk(i_clk),
		.i_srst(1'b0), // unreset: a reset must not fake a frame end
		.i_async(i_cs_n),
		.o_sync(cs_sync)
	);

	bit_sync u_wp_sync
	(
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_async(i_write_protect_or_io2_n),
		.o_sync(wp_sync)
	);

	always_ff @(posedge i_clk)
	begin
		cs_prev <= i_srst ? 1'b1 : cs_sync;
	end

	// link registers are frozen once the serial clock stops with select high
	assign frame_end = cs_sync & ~cs_prev;
	assign frame = '{fresh: ~clocked, bit_cnt: bit_cnt, opcode: opcode, data: shreg[15:0]};

	// ----------------------------------------------------------------
	// core: register write cycle, protection, address mode
	// ----------------------------------------------------------------
	typedef enum logic {ST_IDLE, ST_WRITING} core_state_type;

	core_state_type state;
	core_state_type next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	status_type status;
	status_type next_status;
	config_type cfg;
	config_type next_cfg;
	logic hardware_protect_mode;
	logic cmd_only;
	logic write_len_ok;
	logic [7:0] new_status;
	logic [7:0] new_config;
	logic pe_protected;
	logic next_pe_protected;

	function automatic logic region_hit(input logic [ADDR_W-1:0] addr,
		input logic [3:0] level, input logic bottom);
		logic [ADDR_W:0] size;
		logic [ADDR_W:0] total;
		logic hit;
		total = {1'b1, {ADDR_W{1'b0}}};
		size = {{ADDR_W{1'b0}}, 1'b1} << (BLOCK_ADDR_W + int'(level) - 1);
		if (BLOCK_ADDR_W + int'(level) - 1 >= ADDR_W || level == 4'hf) // shift would overflow
			size = total;
		if (level == 4'h0)
			hit = 1'b0;
		else if (bottom)
			hit = {1'b0, addr} < size;
		else
			hit = {1'b0, addr} >= total - size;
		return hit;
	endfunction

	always_comb
	begin
		hardware_protect_mode = status.status_write_lock & ~wp_sync & ~status.quad_enable_flag
			& ~i_four_wire_cmd_mode; // R11 R12 R13
		cmd_only = ~frame.fresh && frame.bit_cnt == BITS_OPCODE;
		write_len_ok = ~frame.fresh &&
			(frame.bit_cnt == BITS_ONE_DATA || frame.bit_cnt == BITS_TWO_DATA); // R6
		new_status = (frame.bit_cnt == BITS_TWO_DATA) ? frame.data[15:8] : frame.data[7:0];
		new_config = frame.data[7:0];
		next_state = state;
		next_timer = timer;
		next_status = status;
		next_cfg = cfg;
		case (state)
			ST_IDLE:
			begin
				if (frame_end && cmd_only && frame.opcode == OP_WRITE_ENABLE)
					next_status.write_latch_flag = 1'b1; // R9
				if (frame_end && frame.opcode == OP_WRITE_STATUS && write_len_ok &&
					status.write_latch_flag && !hardware_protect_mode) // R4 R10 R24
				begin
					next_status.status_write_lock = new_status[7]; // R3
					next_status.quad_enable_flag = new_status[6];
					next_status.protect_level = new_status[5:2];
					if (frame.bit_cnt == BITS_TWO_DATA)
					begin
						next_cfg.dummy_count_select = new_config[7:6];
						// one-time bit: a write can set it, only reset clears it
						next_cfg.protect_origin_select = cfg.protect_origin_select | new_config[3];
						next_cfg.drive_strength = new_config[2:0];
					end
					next_status.busy_flag = 1'b1; // R7 R8
					next_timer = '0;
					next_state = ST_WRITING;
				end
			end
			ST_WRITING:
			begin
				if (timer == TIMER_W'(REG_WRITE_CYCLES - 1))
				begin
					next_status.busy_flag = 1'b0; // R8
					next_status.write_latch_flag = 1'b0;
					next_state = ST_IDLE;
				end
				else
					next_timer = timer + 1'b1;
			end
			default:
				next_state = ST_IDLE;
		endcase
		// address mode switches are honoured even while busy
		if (frame_end && cmd_only && frame.opcode == OP_ENTER_WIDE)
			next_cfg.wide_addr_indicator = 1'b1; // R16
		if (frame_end && cmd_only && frame.opcode == OP_EXIT_WIDE)
			next_cfg.wide_addr_indicator = 1'b0; // R20
		next_pe_protected = region_hit(i_pe_addr, status.protect_level,
			cfg.protect_origin_select); // R14
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state <= ST_IDLE;
			timer <= '0;
			status <= status_type'(STATUS_RESET);
			cfg <= config_type'(CONFIG_RESET); // R17 R25
			pe_protected <= 1'b0;
		end
		else
		begin
			state <= next_state;
			timer <= next_timer;
			status <= next_status;
			cfg <= next_cfg;
			pe_protected <= next_pe_protected;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic hpm_q;
	logic pe_allowed;
	logic [3:0] dummy_out_q;
	logic [3:0] dummy_dual_q;
	logic [3:0] dummy_quad_q;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			hpm_q <= 1'b0;
			pe_allowed <= 1'b0;
			dummy_out_q <= 4'h8;
			dummy_dual_q <= 4'h4;
			dummy_quad_q <= 4'h6;
		end
		else
		begin
			hpm_q <= hardware_protect_mode;
			pe_allowed <= status.write_latch_flag & ~status.busy_flag
				& ~next_pe_protected; // R24
			dummy_out_q <= dummy_clocks(cfg.dummy_count_select, KIND_FAST_OUTPUT); // R1
			dummy_dual_q <= dummy_clocks(cfg.dummy_count_select, KIND_DUAL_IO);
			dummy_quad_q <= dummy_clocks(cfg.dummy_count_select, KIND_QUAD_IO);
		end
	end

	assign o_status = status;
	assign o_config = cfg;
	assign o_pe_protected = pe_protected;
	assign o_pe_allowed = pe_allowed;
	assign o_hardware_protect_mode = hpm_q;
	assign o_dummy_fast_output = dummy_out_q;
	assign o_dummy_dual_io = dummy_dual_q;
	assign o_dummy_quad_io = dummy_quad_q;
endmodule // serial_flash_cmd
`default_nettype wire

//--- serial_flash_cmd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_monitor
#(
	parameter int REG_WRITE_CYCLES = 20
)
(
	input wire logic i_clk, // core clock
	input wire logic i_srst, // sync reset
	input wire logic i_write_protect_or_io2_n, // protect pin
	input wire logic i_four_wire_cmd_mode, // four-wire mode
	input wire logic o_pe_allowed, // program/erase allowed
	input wire flash_cmd_pkg::status_type o_status, // status
	input wire flash_cmd_pkg::config_type o_config, // config
	input wire logic o_hardware_protect_mode, // hardware protect
	input wire logic [3:0] o_dummy_fast_output // dummy count
);
	import flash_cmd_pkg::*;
	logic [15:0] busy_len;
	logic [15:0] next_busy_len;
	logic [1:0] dsel;
	assign dsel = o_config.dummy_count_select;
	always_comb
		next_busy_len = o_status.busy_flag ? busy_len + 16'h0001 : 16'h0000;
	always_ff @(posedge i_clk)
		busy_len <= i_srst ? 16'h0000 : next_busy_len;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// hold of two cycles: the register lags the refusal decision by one
	sequence s_hpm_held;
		o_hardware_protect_mode ##1 o_hardware_protect_mode;
	endsequence
	sequence s_hpm_cause;
		(o_status.status_write_lock && !o_status.quad_enable_flag &&
			!i_write_protect_or_io2_n && !i_four_wire_cmd_mode) [*5];
	endsequence
	property p_busy_len;
		$fell(o_status.busy_flag) |-> busy_len == REG_WRITE_CYCLES && !o_status.write_latch_flag;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy span or latch wrong");
	property p_start_latch;
		$rose(o_status.busy_flag) |-> o_status.write_latch_flag && $past(o_status.write_latch_flag);
	endproperty
	a_start_latch: assert property (p_start_latch) else $error("write without latch");
	property p_hpm_refuse;
		s_hpm_held |-> !$rose(o_status.busy_flag);
	endproperty
	a_hpm_refuse: assert property (p_hpm_refuse) else $error("write in hw protect");
	property p_hpm_enter;
		s_hpm_cause |-> o_hardware_protect_mode;
	endproperty
	a_hpm_enter: assert property (p_hpm_enter) else $error("hw protect not entered");
	property p_hpm_leave;
		i_write_protect_or_io2_n [*4] |-> !o_hardware_protect_mode;
	endproperty
	a_hpm_leave: assert property (p_hpm_leave) else $error("hw protect not left");
	property p_quad_off;
		o_status.quad_enable_flag || i_four_wire_cmd_mode |=> !o_hardware_protect_mode;
	endproperty
	a_quad_off: assert property (p_quad_off) else $error("hw protect not disabled");
	property p_pe_allowed;
		o_pe_allowed |-> $past(o_status.write_latch_flag) && !$past(o_status.busy_flag);
	endproperty
	a_pe_allowed: assert property (p_pe_allowed) else $error("program allowed wrongly");
	property p_dummy;
		$stable(dsel) |-> o_dummy_fast_output == (dsel == 2'h1 ? 4'h6 : dsel == 2'h3 ? 4'ha : 4'h8);
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy count wrong");
endmodule // serial_flash_cmd_monitor

bind serial_flash_cmd serial_flash_cmd_monitor #(.REG_WRITE_CYCLES(REG_WRITE_CYCLES)) mon_u (
	.i_clk(i_clk), .i_srst(i_srst), .i_write_protect_or_io2_n(i_write_protect_or_io2_n),
	.i_four_wire_cmd_mode(i_four_wire_cmd_mode), .o_pe_allowed(o_pe_allowed),
	.o_status(o_status), .o_config(o_config), .o_hardware_protect_mode(o_hardware_protect_mode),
	.o_dummy_fast_output(o_dummy_fast_output)
);
`default_nettype wire

//--- flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_model
(
	output logic o_cs_n, // chip select
	output logic o_sclk, // serial clock, only in frames
	output logic o_si, // data to device
	input wire logic i_so // data from device
);
	initial
	begin
		o_cs_n = 1'b0;
		o_sclk = 1'b0;
		o_si = 1'b0;
		// one defined rising select edge settles the frame flags
		#1 o_cs_n = 1'b1;
	end
	// 12 ns serial clock, mode 0; data read on rising edges
	task automatic xfer(input logic [47:0] tx, input int ntx, input int nrx, output logic [23:0] rx);
		rx = '0;
		#7 o_cs_n = 1'b0;
		for (int i = 0; i < ntx + nrx; i++)
		begin
			#3 o_si = (i < ntx) ? tx[ntx-1-i] : ~o_si;
			#3 o_sclk = 1'b1;
			if (i >= ntx)
				rx = {rx[22:0], i_so};
			#6 o_sclk = 1'b0;
		end
		#3 o_cs_n = 1'b1;
		o_si = ~o_si; // undriven line: never leave a stale level
		#30;
	endtask
endmodule // flash_host_model
`default_nettype wire

//--- serial_flash_write_status_cmd_protect_addr_read_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_status_cmd_protect_addr_read_tb_top;
	import flash_cmd_pkg::*;
	localparam int AW = 17;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic cs_n, sclk, si, so, so_oe_n, pe_prot, pe_ok, hardware_protect_mode;
	logic wp_n = 1'b1;
	logic four_wire = 1'b0;
	logic [AW-1:0] rd_addr;
	logic [AW-1:0] pe_addr = '0;
	logic [7:0] rd_data, exp_st, exp_cf;
	logic [3:0] d_fast, d_dual, d_quad;
	logic [3:0] dtab [4] = '{4'h8, 4'h6, 4'h8, 4'ha};
	logic [3:0] dtab_dual [4] = '{4'h4, 4'h6, 4'h8, 4'ha};
	logic [3:0] dtab_quad [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
	status_type st;
	config_type cf;
	logic [15:0] r;
	logic [23:0] rx;
	int n_fail = 0;
	int compares = 0;
	int seed = 38808;
	int n_drive = 0;

	always #2.5 i_clk = ~i_clk;

	// serial clocks on which the device drives its output
	always @(posedge sclk)
		if (!so_oe_n)
			n_drive++;

	function automatic logic [7:0] mem(input logic [AW-1:0] a);
		return a[7:0] ^ {a[11:8], a[15:12]};
	endfunction
	assign rd_data = mem(rd_addr);

	serial_flash_cmd #(.ADDR_W(AW), .REG_WRITE_CYCLES(20)) dut_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so),
		.o_so_oe_n(so_oe_n), .i_write_protect_or_io2_n(wp_n), .i_four_wire_cmd_mode(four_wire),
		.o_array_addr(rd_addr), .i_array_data(rd_data), .i_pe_addr(pe_addr),
		.o_pe_protected(pe_prot), .o_pe_allowed(pe_ok), .o_status(st), .o_config(cf),
		.o_hardware_protect_mode(hardware_protect_mode), .o_dummy_fast_output(d_fast), .o_dummy_dual_io(d_dual),
		.o_dummy_quad_io(d_quad)
	);
	flash_host_model host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic cmd(input logic [23:0] tx, input int n);
		host_u.xfer({24'h0, tx}, n, 0, rx);
		step(2);
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		while (st.busy_flag !== 1'b0 && k < 200)
		begin
			step(1);
			k++;
		end
		chk("busy end", k < 200, 1);
	endtask
	task automatic write_status_cmd(input logic [15:0] v, input int nb);
		logic ok;
		cmd(OP_WRITE_ENABLE, 8);
		exp_st[1] = 1'b1;
		ok = (nb == 8 || nb == 16) && !(exp_st[7] && !wp_n && !exp_st[6] && !four_wire);
		cmd({OP_WRITE_STATUS, v} >> (16 - nb), 8 + nb);
		if (ok)
		begin
			chk("busy", st, {v[15:10], 2'b11});
			exp_st = {v[15:10], 2'b00};
			if (nb == 16)
				exp_cf = {v[7:6], exp_cf[5], 1'b0, exp_cf[3] | v[3], v[2:0]};
			wait_idle;
		end
		chk("status", st, exp_st);
		chk("config", cf, exp_cf);
		chk("dummy", d_fast, dtab[exp_cf[7:6]]);
		chk("dummy io", {d_dual, d_quad}, {dtab_dual[exp_cf[7:6]], dtab_quad[exp_cf[7:6]]});
	endtask
	task automatic rd(input logic [31:0] a, input int nab);
		logic [AW-1:0] p;
		logic [7:0] q [$];
		int d0;
		p = a[AW-1:0];
		d0 = n_drive;
		for (int j = 0; j < 3; j++)
			q.push_back(mem(p + AW'(j)));
		host_u.xfer(nab == 4 ? {OP_READ, a} : {OP_READ, a[23:0]}, 8 + nab * 8, 24, rx);
		chk("read", rx, {q[0], q[1], q[2]});
		chk("drive bits", n_drive - d0, 24);
		chk("float", so_oe_n, 1'b1);
		step(2);
	endtask
	task automatic summarize;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		n_fail++;
		summarize;
	end

	initial
	begin
		exp_st = STATUS_RESET;
		exp_cf = CONFIG_RESET;
		step(10);
		i_srst = 1'b0;
		step(3);
		chk("status", st, exp_st);
		chk("config", cf, exp_cf);
		chk("dummies", {d_fast, d_dual, d_quad}, 12'h846);
		cmd({OP_WRITE_STATUS, 8'h3c}, 16);
		chk("no latch", st, exp_st);
		write_status_cmd(16'h3c00, 12);
		for (int i = 0; i < 4; i++)
		begin
			r = 16'($random(seed));
			write_status_cmd({1'b0, r[14:8], i[1:0], r[5:0]}, 16);
		end
		write_status_cmd(16'h8000, 8);
		wp_n = 1'b0;
		step(5);
		chk("hpm on", hardware_protect_mode, 1'b1);
		write_status_cmd(16'h0000, 8);
		four_wire = 1'b1;
		step(2);
		chk("hpm four wire", hardware_protect_mode, 1'b0);
		four_wire = 1'b0;
		wp_n = 1'b1;
		step(5);
		chk("hpm off", hardware_protect_mode, 1'b0);
		write_status_cmd(16'hc000, 8);
		wp_n = 1'b0;
		step(5);
		chk("hpm quad", hardware_protect_mode, 1'b0);
		wp_n = 1'b1;
		write_status_cmd(16'h3c00, 8);
		pe_addr = AW'($random(seed));
		step(3);
		chk("pe all", {pe_prot, pe_ok}, 2'b10);
		write_status_cmd(16'h0000, 8);
		cmd(OP_WRITE_ENABLE, 8);
		chk("pe free", {pe_prot, pe_ok}, 2'b01);
		cmd(OP_ENTER_WIDE, 8);
		exp_cf[5] = 1'b1;
		chk("wide", cf, exp_cf);
		rd({r[15:1], 1'b1, 16'hfffe}, 4);
		cmd(OP_EXIT_WIDE, 8);
		exp_cf[5] = 1'b0;
		chk("narrow", cf, exp_cf);
		for (int i = 0; i < 3; i++)
			rd($random(seed), 3);
		cmd(OP_ENTER_WIDE, 8);
		i_srst = 1'b1;
		step(3);
		i_srst = 1'b0;
		step(3);
		chk("wide reset", cf, CONFIG_RESET);
		summarize;
	end
endmodule // serial_flash_write_status_cmd_protect_addr_read_tb_top
`default_nettype wire
